//--- logic/msxac_memory_steer.sv
// Purpose: Code fetch selection, internal data decode and ONCHIP_XDATA_RAM steering
// Assumes: Core presents one external data move per request pulse
// Notes:   ONCHIP_XDATA_RAM contents survive reset; port pin behaviour lives elsewhere
// How it works
// - Pin high: ROM to 7FFF, external above
// - Pin low: all code fetched externally
// - Lower direct/indirect, upper indirect, special direct
// - 00-1F four banks, status bits select
// - Bytes 20-2F bit addressable, 128 bits
// - Opcode register in bank; pointer registers
// - Reset stack pointer to 07
// - Stack spans all 256 internal bytes
// - ONCHIP_XDATA_RAM at FC00-FFFF via data moves only
// - Disable clear: range moves hit ONCHIP_XDATA_RAM
// - Disable set after reset: all external
// - Disable bit settable only by reset
// - Visible clear: strobes quiet on ONCHIP_XDATA_RAM
// - Visible set: strobes, address, data out
// - Control at B1, reset XX10XX01, reserved undefined
// - Pointer moves reach ONCHIP_XDATA_RAM only in range
// - Page register gives high byte, 8-bit moves
// - Port two write also loads page register
`timescale 1ns/1ps
module msxac_memory_steer
   import msxac_pkg::*;
(
   // Clock and control
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic          clkEn,
   // Code fetch
   input  wire logic          extAccessPin,
   input  wire logic [15:0]   progCounter,
   output logic               fetchExternal,
   // Special register bus
   input  wire logic          sfrWrite,
   input  wire logic          sfrRead,
   input  wire logic [7:0]    sfrAddr,
   input  wire logic [7:0]    sfrWdata,
   output logic [7:0]         sfrRdata,
   output logic               sfrHit,
   // Internal data decode
   input  wire msxac_mode_t   dataMode,
   input  wire logic [7:0]    dataAddr,
   input  wire logic [2:0]    opcodeReg,
   output logic [7:0]         ramIndex,
   output logic               ramSelect,
   output logic               sfrSelect,
   output logic [2:0]         bitIndex,
   output logic [7:0]         stackPointer,
   output logic [7:0]         statusWord,
   // Pointer registers of active bank and 16-bit data pointer
   input  wire logic [7:0]    pointerRegZero,
   input  wire logic [7:0]    pointerRegOne,
   input  wire logic [15:0]   dataPointer,
   // External data move
   input  wire msxac_xreq_t   xReq,
   output logic [7:0]         xramRdata,
   output logic               xramHit,
   output msxac_xbus_t        xBus,
   output logic [7:0]         portTwoLatch
);

   logic        xramDisable_reg;
   logic        xramVisible_reg;
   logic [7:0]  xramPage_reg;
   logic [7:0]  portTwo_reg;
   logic [7:0]  stack_reg;
   logic [7:0]  status_reg;
   logic [7:0]  xramRdata_reg;
   logic        xramHit_reg;
   msxac_xbus_t xBus_reg;
   logic [7:0]  onchip_xdata_ram [0:ONCHIP_XDATA_RAM_DEPTH-1];

   logic [15:0] effAddr;
   logic        inRange;
   logic        useXram;
   logic [1:0]  bankSel;

   // Code space selection
   assign fetchExternal = !extAccessPin || (progCounter > ROM_TOP);

   // Control register: disable bit is one-way under software
   always_ff @(posedge clk) begin
      if (reset) begin
         xramDisable_reg <= ONCHIP_XDATA_RAM_DIS_RESET;
         xramVisible_reg <= ONCHIP_XDATA_RAM_VIS_RESET;
      end else if (clkEn && sfrWrite && sfrAddr == SYS_CTL_ADDR) begin
         if (!sfrWdata[ONCHIP_XDATA_RAM_DIS_BIT]) begin
            xramDisable_reg <= 1'b0;
         end
         xramVisible_reg <= sfrWdata[ONCHIP_XDATA_RAM_VIS_BIT];
      end
   end

   // Port two latch and page register
   always_ff @(posedge clk) begin
      if (reset) begin
         xramPage_reg <= ONCHIP_XDATA_RAM_PAGE_RESET;
         portTwo_reg  <= PORT2_RESET;
      end else if (clkEn && sfrWrite) begin
         if (sfrAddr == PORT2_ADDR) begin
            portTwo_reg  <= sfrWdata;
            xramPage_reg <= sfrWdata;
         end else if (sfrAddr == ONCHIP_XDATA_RAM_PAGE_ADDR) begin
            xramPage_reg <= sfrWdata;
         end
      end
   end

   // Stack pointer and status word
   always_ff @(posedge clk) begin
      if (reset) begin
         stack_reg  <= STACK_RESET;
         status_reg <= STATUS_RESET;
      end else if (clkEn && sfrWrite) begin
         if (sfrAddr == STACK_ADDR) begin
            stack_reg <= sfrWdata;
         end
         if (sfrAddr == STATUS_ADDR) begin
            status_reg <= sfrWdata;
         end
      end
   end

   assign stackPointer = stack_reg;
   assign statusWord   = status_reg;
   assign portTwoLatch = portTwo_reg;

   // Special register read; reserved control bits read as fixed pattern
   always_comb begin
      sfrHit   = 1'b1;
      sfrRdata = 8'h00_00;
      unique case (sfrAddr)
         SYS_CTL_ADDR: sfrRdata = SYS_CTL_FIXED
                                 | {6'h00, xramVisible_reg, xramDisable_reg};
         ONCHIP_XDATA_RAM_PAGE_ADDR: sfrRdata = xramPage_reg;
         PORT2_ADDR:  sfrRdata = portTwo_reg;
         STACK_ADDR:  sfrRdata = stack_reg;
         STATUS_ADDR: sfrRdata = status_reg;
         default:     sfrHit   = 1'b0;
      endcase
      if (!sfrRead) begin
         sfrHit = 1'b0;
      end
   end

   // Internal data decode
   assign bankSel = {status_reg[BANK_HI_BIT], status_reg[BANK_LO_BIT]};

   always_comb begin
      ramIndex  = dataAddr;
      ramSelect = 1'b0;
      sfrSelect = 1'b0;
      bitIndex  = 3'd0;
      unique case (dataMode)
         MSXAC_AM_DIRECT: begin
            ramSelect = (dataAddr <= LOWER_TOP);
            sfrSelect = (dataAddr >  LOWER_TOP);
         end
         MSXAC_AM_INDIRECT: begin
            ramSelect = 1'b1;
         end
         MSXAC_AM_REGISTER: begin
            ramIndex  = {3'b000, bankSel, opcodeReg};
            ramSelect = 1'b1;
         end
         MSXAC_AM_BIT: begin
            if (dataAddr[7]) begin
               ramIndex  = {dataAddr[7:3], 3'b000};
               sfrSelect = 1'b1;
            end else begin
               ramIndex  = BITAREA_LO + {4'h0, dataAddr[6:3]};
               ramSelect = 1'b1;
            end
            bitIndex = dataAddr[2:0];
         end
      endcase
   end

   // External data address: 8-bit moves put the page register on top
   always_comb begin
      if (xReq.viaPointer) begin
         effAddr = dataPointer;
      end else begin
         effAddr = {xramPage_reg, xReq.ptrSel ? pointerRegOne : pointerRegZero};
      end
   end

   assign inRange = (effAddr[15:10] == ONCHIP_XDATA_RAM_HI_TAG);
   assign useXram = xReq.valid && inRange && !xramDisable_reg;

   // ONCHIP_XDATA_RAM array; no reset so contents survive
   always_ff @(posedge clk) begin
      if (clkEn && useXram && xReq.write) begin
         onchip_xdata_ram[effAddr[ONCHIP_XDATA_RAM_AW-1:0]] <= xReq.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         xramRdata_reg <= 8'h00_00;
         xramHit_reg   <= 1'b0;
      end else if (clkEn) begin
         xramHit_reg <= useXram;
         if (useXram && !xReq.write) begin
            xramRdata_reg <= onchip_xdata_ram[effAddr[ONCHIP_XDATA_RAM_AW-1:0]];
         end
      end
   end

   assign xramRdata = xramRdata_reg;
   assign xramHit   = xramHit_reg;

   // External bus cycle; ONCHIP_XDATA_RAM cycles shown only when visible
   always_ff @(posedge clk) begin
      if (reset) begin
         xBus_reg <= '0;
      end else if (clkEn) begin
         xBus_reg <= '0;
         if (xReq.valid && (!useXram || xramVisible_reg)) begin
            xBus_reg.rdActive <= !xReq.write;
            xBus_reg.wrActive <= xReq.write;
            xBus_reg.busDrive <= 1'b1;
            xBus_reg.addr     <= effAddr;
            xBus_reg.wdata    <= xReq.wdata;
         end
      end
   end

   assign xBus = xBus_reg;

   chk_code_select: assert property (@(posedge clk) disable iff (reset)
      (extAccessPin && progCounter <= ROM_TOP) |-> !fetchExternal)
      else $error("internal code fetch routed outside");
   chk_code_ext: assert property (@(posedge clk) disable iff (reset)
      !extAccessPin |-> fetchExternal)
      else $error("external code fetch not taken");
   chk_disable_sticky: assert property (@(posedge clk) disable iff (reset)
      (clkEn && !xramDisable_reg) |=> !xramDisable_reg)
      else $error("disable bit set by software");
   chk_reset_values: assert property (@(posedge clk)
      reset |=> (xramDisable_reg && stack_reg == STACK_RESET))
      else $error("reset values wrong");
   chk_strobe_quiet: assert property (@(posedge clk) disable iff (reset)
      (clkEn && useXram && !xramVisible_reg) |=> !xBus.rdActive && !xBus.wrActive)
      else $error("strobe during hidden ONCHIP_XDATA_RAM access");
   chk_strobe_visible: assert property (@(posedge clk) disable iff (reset)
      (clkEn && useXram && xramVisible_reg) |=> (xBus.rdActive || xBus.wrActive)
         && xBus.addr == $past(effAddr))
      else $error("visible ONCHIP_XDATA_RAM access not shown");
   chk_disabled_ext: assert property (@(posedge clk) disable iff (reset)
      (clkEn && xReq.valid && xramDisable_reg) |=> xBus.busDrive && !xramHit)
      else $error("disabled ONCHIP_XDATA_RAM still used");
   chk_page_load: assert property (@(posedge clk) disable iff (reset)
      (clkEn && sfrWrite && sfrAddr == PORT2_ADDR) |=> xramPage_reg == $past(sfrWdata))
      else $error("page register missed port write");
   chk_range_hit: assert property (@(posedge clk) disable iff (reset)
      (clkEn && xReq.valid && !xramDisable_reg && effAddr[15:10] != ONCHIP_XDATA_RAM_HI_TAG)
         |=> !xramHit)
      else $error("out of range move hit ONCHIP_XDATA_RAM");

   // Code fetch checks
   chk_fetch_upper: assert property (@(posedge clk) disable iff (reset)
      (extAccessPin && progCounter > ROM_TOP) |-> fetchExternal)
      else $error("upper code fetch not external");

   // Internal data checks
   chk_bank_index: assert property (@(posedge clk) disable iff (reset)
      (dataMode == MSXAC_AM_REGISTER) |-> ramIndex[7:3] == {3'b000, statusWord[4:3]})
      else $error("register index outside active bank");

   chk_bank_reg: assert property (@(posedge clk) disable iff (reset)
      (dataMode == MSXAC_AM_REGISTER) |-> ramIndex[2:0] == opcodeReg)
      else $error("register number not from opcode");

   chk_bank_range: assert property (@(posedge clk) disable iff (reset)
      (dataMode == MSXAC_AM_REGISTER) |-> ramIndex <= BANK_TOP)
      else $error("register bank above bank area");

   chk_upper_ind: assert property (@(posedge clk) disable iff (reset)
      (dataMode == MSXAC_AM_INDIRECT) |-> ramSelect && !sfrSelect)
      else $error("indirect access not to RAM");

   chk_direct_split: assert property (@(posedge clk) disable iff (reset)
      (dataMode == MSXAC_AM_DIRECT) |-> (ramSelect != sfrSelect) && (sfrSelect == dataAddr[7]))
      else $error("direct access split wrong");

   chk_bit_area: assert property (@(posedge clk) disable iff (reset)
      (dataMode == MSXAC_AM_BIT && !dataAddr[7])
         |-> ramSelect && ramIndex >= BITAREA_LO && ramIndex <= BITAREA_HI)
      else $error("bit access outside bit area");

   // Control register and other special register checks
   chk_disable_clear: assert property (@(posedge clk) disable iff (reset)
      (clkEn && sfrWrite && sfrAddr == SYS_CTL_ADDR && !sfrWdata[ONCHIP_XDATA_RAM_DIS_BIT])
         |=> !xramDisable_reg)
      else $error("disable bit not cleared");

   chk_visible_load: assert property (@(posedge clk) disable iff (reset)
      (clkEn && sfrWrite && sfrAddr == SYS_CTL_ADDR)
         |=> xramVisible_reg == $past(sfrWdata[ONCHIP_XDATA_RAM_VIS_BIT]))
      else $error("visible bit not loaded");

   chk_ctl_readback: assert property (@(posedge clk) disable iff (reset)
      (sfrRead && sfrAddr == SYS_CTL_ADDR) |-> sfrHit && sfrRdata[1] == xramVisible_reg)
      else $error("control register read wrong");

   chk_stack_load: assert property (@(posedge clk) disable iff (reset)
      (clkEn && sfrWrite && sfrAddr == STACK_ADDR) |=> stackPointer == $past(sfrWdata))
      else $error("stack pointer not loaded");

   chk_page_direct: assert property (@(posedge clk) disable iff (reset)
      (clkEn && sfrWrite && sfrAddr == ONCHIP_XDATA_RAM_PAGE_ADDR) |=> xramPage_reg == $past(sfrWdata))
      else $error("page register not loaded");

   chk_port_latch: assert property (@(posedge clk) disable iff (reset)
      (clkEn && sfrWrite && sfrAddr == PORT2_ADDR) |=> portTwoLatch == $past(sfrWdata))
      else $error("port two latch not loaded");

   chk_freeze_state: assert property (@(posedge clk) disable iff (reset)
      !clkEn |=> $stable(stack_reg) && $stable(xramDisable_reg) && $stable(xramPage_reg))
      else $error("state moved with clock enable low");

   // External move checks
   chk_onchip_xdata_ram_hit: assert property (@(posedge clk) disable iff (reset)
      (clkEn && xReq.valid && !xramDisable_reg && inRange) |=> xramHit)
      else $error("in range move missed ONCHIP_XDATA_RAM");

   chk_ext_outside: assert property (@(posedge clk) disable iff (reset)
      (clkEn && xReq.valid && !inRange) |=> xBus.busDrive && !xramHit)
      else $error("out of range move not external");

   chk_pointer_addr: assert property (@(posedge clk) disable iff (reset)
      (xReq.valid && xReq.viaPointer) |-> effAddr == dataPointer)
      else $error("pointer address not used");

   chk_page_addr: assert property (@(posedge clk) disable iff (reset)
      (xReq.valid && !xReq.viaPointer) |-> effAddr[15:8] == xramPage_reg)
      else $error("page byte not on high address");

   chk_visible_data: assert property (@(posedge clk) disable iff (reset)
      (clkEn && useXram && xramVisible_reg && xReq.write)
         |=> xBus.wrActive && xBus.wdata == $past(xReq.wdata))
      else $error("visible write data not shown");

   chk_hidden_drive: assert property (@(posedge clk) disable iff (reset)
      (clkEn && useXram && !xramVisible_reg) |=> !xBus.busDrive)
      else $error("bus driven on hidden ONCHIP_XDATA_RAM access");

endmodule // msxac_memory_steer

//--- logic/msxac_pkg.sv
// Purpose: Constants and carriers for the memory space and ONCHIP_XDATA_RAM steering block
// Assumes: 8-bit core with 16-bit code and external data address spaces
// Notes:   Special register addresses are the core's direct addresses
package msxac_pkg;

   localparam logic [7:0]  SYS_CTL_ADDR    = 8'h00_B1;
   localparam logic [7:0]  ONCHIP_XDATA_RAM_PAGE_ADDR  = 8'h00_91;
   localparam logic [7:0]  PORT2_ADDR      = 8'h00_A0;
   localparam logic [7:0]  STATUS_ADDR     = 8'h00_D0;
   localparam logic [7:0]  STACK_ADDR      = 8'h00_81;
   localparam int          ONCHIP_XDATA_RAM_DIS_BIT    = 0;
   localparam int          ONCHIP_XDATA_RAM_VIS_BIT    = 1;
   localparam int          BANK_LO_BIT     = 3;
   localparam int          BANK_HI_BIT     = 4;
   localparam logic        ONCHIP_XDATA_RAM_DIS_RESET  = 1'b1;
   localparam logic        ONCHIP_XDATA_RAM_VIS_RESET  = 1'b0;
   localparam logic [7:0]  SYS_CTL_FIXED   = 8'h00_20;
   localparam logic [7:0]  STACK_RESET     = 8'h00_07;
   localparam logic [7:0]  ONCHIP_XDATA_RAM_PAGE_RESET = 8'h00_00;
   localparam logic [7:0]  PORT2_RESET     = 8'h00_FF;
   localparam logic [7:0]  STATUS_RESET    = 8'h00_00;
   localparam logic [15:0] ROM_TOP         = 16'h7FFF;
   localparam logic [5:0]  ONCHIP_XDATA_RAM_HI_TAG     = 6'h3F;
   localparam int          ONCHIP_XDATA_RAM_DEPTH      = 1024;
   localparam int          ONCHIP_XDATA_RAM_AW         = 10;
   localparam logic [7:0]  LOWER_TOP       = 8'h00_7F;
   localparam logic [7:0]  BANK_TOP        = 8'h00_1F;
   localparam logic [7:0]  BITAREA_LO      = 8'h00_20;
   localparam logic [7:0]  BITAREA_HI      = 8'h00_2F;

   typedef enum logic [1:0] {
      MSXAC_AM_DIRECT,
      MSXAC_AM_INDIRECT,
      MSXAC_AM_REGISTER,
      MSXAC_AM_BIT
   } msxac_mode_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        viaPointer;
      logic        ptrSel;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } msxac_xreq_t;

   typedef struct packed {
      logic        rdActive;
      logic        wrActive;
      logic        busDrive;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } msxac_xbus_t;

endpackage

//--- tb/msxac_ext_mem.sv
// Purpose: External data memory seen on the multiplexed bus
// Assumes: Each bus cycle is a one-cycle strobe pulse
// Notes:   Records the last cycle and counts cycles for the bench
`timescale 1ns/1ps
module msxac_ext_mem
   import msxac_pkg::*;
(
   // Clock
   input  wire logic         clk,
   // Bus
   input  wire msxac_xbus_t  xBus,
   output logic [15:0]       lastAddr,
   output int                cycles
);
   initial cycles = 0;
   always @(posedge clk) begin
      if (xBus.rdActive || xBus.wrActive) begin
         cycles   <= cycles + 1;
         lastAddr <= xBus.addr;
      end
   end
endmodule // msxac_ext_mem

//--- tb/tb.sv
// Purpose: Self-checking bench for the memory space and ONCHIP_XDATA_RAM steering block
// Assumes: Inputs change on the falling edge
// Notes:   Scenarios run in order and share ONCHIP_XDATA_RAM contents
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin nCompared++; if ((gt) !== (ex)) begin errTotal++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb;
   import msxac_pkg::*;
   logic        clk, reset, extAccessPin, sfrWrite, sfrRead, xramHit, fetchExternal;
   logic        clkEn;
   logic        ramSelect, sfrSelect, sfrHit;
   logic [15:0] progCounter, dataPointer, lastAddr;
   logic [7:0]  sfrAddr, sfrWdata, sfrRdata, dataAddr, pointerRegZero, pointerRegOne;
   logic [7:0]  ramIndex, stackPointer, statusWord, xramRdata, portTwoLatch;
   logic [2:0]  opcodeReg, bitIndex;
   msxac_mode_t dataMode;
   msxac_xreq_t xReq;
   msxac_xbus_t xBus;
   int          errTotal, nCompared, cycles;

   msxac_memory_steer u_dut (.clk(clk), .reset(reset), .clkEn(clkEn),
      .extAccessPin(extAccessPin), .progCounter(progCounter), .fetchExternal(fetchExternal),
      .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
      .sfrRdata(sfrRdata), .sfrHit(sfrHit), .dataMode(dataMode), .dataAddr(dataAddr),
      .opcodeReg(opcodeReg), .ramIndex(ramIndex), .ramSelect(ramSelect),
      .sfrSelect(sfrSelect), .bitIndex(bitIndex), .stackPointer(stackPointer),
      .statusWord(statusWord), .pointerRegZero(pointerRegZero),
      .pointerRegOne(pointerRegOne), .dataPointer(dataPointer), .xReq(xReq),
      .xramRdata(xramRdata), .xramHit(xramHit), .xBus(xBus), .portTwoLatch(portTwoLatch));
   msxac_ext_mem u_ext (.clk(clk), .xBus(xBus), .lastAddr(lastAddr), .cycles(cycles));

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfrAddr  = a;
      sfrWdata = d;
      sfrWrite = 1'b1;
      @(negedge clk);
      sfrWrite = 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sfrAddr = a;
      sfrRead = 1'b1;
      #1 `CHK("sfrRdata", e, sfrRdata)
      `CHK("sfrHit", 1'b1, sfrHit)
      sfrRead = 1'b0;
   endtask
   // One move; outputs of the answer cycle are sampled on return
   task automatic xmv(input logic w, input logic vp, input logic ps, input logic [7:0] d);
      @(negedge clk);
      xReq = '{valid: 1'b1, write: w, viaPointer: vp, ptrSel: ps, addr: 16'h0000, wdata: d};
      @(negedge clk);
      xReq.valid = 1'b0;
   endtask
   task automatic t_reset;
      rdchk(SYS_CTL_ADDR, 8'h21);
      `CHK("portTwoLatch", 8'hFF, portTwoLatch)
      `CHK("stackPointer", 8'h07, stackPointer)
      `CHK("statusWord", 8'h00, statusWord)
   endtask
   task automatic t_fetch;
      extAccessPin = 1'b1;
      progCounter  = 16'h7FFF;
      #1 `CHK("fetch 7FFF", 1'b0, fetchExternal)
      progCounter = 16'h8000;
      #1 `CHK("fetch 8000", 1'b1, fetchExternal)
      extAccessPin = 1'b0;
      progCounter  = 16'h0000;
      #1 `CHK("fetch pin low", 1'b1, fetchExternal)
   endtask
   task automatic t_disabled;
      dataPointer = 16'hFC05;
      xmv(1'b0, 1'b1, 1'b0, 8'h00);
      `CHK("hit disabled", 1'b0, xramHit)
      `CHK("rd disabled", 1'b1, xBus.rdActive)
   endtask
   task automatic t_enable;
      wr(SYS_CTL_ADDR, 8'h00);
      wr(SYS_CTL_ADDR, 8'h01);
      rdchk(SYS_CTL_ADDR, 8'h20);
      xmv(1'b1, 1'b1, 1'b0, 8'h5A);
      `CHK("hit FC05", 1'b1, xramHit)
      `CHK("wr quiet", 1'b0, xBus.wrActive)
      dataPointer = 16'hFE05;
      xmv(1'b1, 1'b1, 1'b0, 8'hC3);
      dataPointer = 16'hFC05;
      xmv(1'b0, 1'b1, 1'b0, 8'h00);
      `CHK("data FC05", 8'h5A, xramRdata)
      `CHK("rd quiet", 1'b0, xBus.rdActive)
      dataPointer = 16'hFBFF;
      xmv(1'b0, 1'b1, 1'b0, 8'h00);
      `CHK("hit FBFF", 1'b0, xramHit)
   endtask
   task automatic t_visible;
      wr(SYS_CTL_ADDR, 8'h02);
      dataPointer = 16'hFC06;
      xmv(1'b1, 1'b1, 1'b0, 8'h77);
      `CHK("vis hit", 1'b1, xramHit)
      `CHK("vis wr", 1'b1, xBus.wrActive)
      `CHK("vis addr", 16'hFC06, xBus.addr)
      `CHK("vis data", 8'h77, xBus.wdata)
      dataPointer = 16'hFBFF;
      xmv(1'b0, 1'b1, 1'b0, 8'h00);
      `CHK("vis outside", 1'b0, xramHit)
      wr(SYS_CTL_ADDR, 8'h00);
   endtask
   task automatic t_page;
      wr(ONCHIP_XDATA_RAM_PAGE_ADDR, 8'hFF);
      pointerRegOne = 8'h30;
      xmv(1'b1, 1'b0, 1'b1, 8'hE1);
      `CHK("page hit", 1'b1, xramHit)
      dataPointer = 16'hFF30;
      xmv(1'b0, 1'b1, 1'b0, 8'h00);
      `CHK("page data", 8'hE1, xramRdata)
      wr(PORT2_ADDR, 8'hAA);
      rdchk(ONCHIP_XDATA_RAM_PAGE_ADDR, 8'hAA);
      `CHK("port latch", 8'hAA, portTwoLatch)
      pointerRegZero = 8'h30;
      xmv(1'b0, 1'b0, 1'b0, 8'h00);
      `CHK("page ext", 1'b0, xramHit)
      @(negedge clk);
      `CHK("bus addr", 16'hAA30, lastAddr)
      `CHK("bus cycles", 5, cycles)
   endtask
   task automatic t_decode;
      for (int b = 0; b < 4; b++) begin
         wr(STATUS_ADDR, 8'(b << 3));
         dataMode  = MSXAC_AM_REGISTER;
         opcodeReg = 3'd5;
         #1 `CHK("bank index", {3'b000, 2'(b), 3'd5}, ramIndex)
      end
      dataMode = MSXAC_AM_INDIRECT;
      dataAddr = 8'h90;
      #1 `CHK("upper ind", 2'b10, {ramSelect, sfrSelect})
      dataMode = MSXAC_AM_DIRECT;
      #1 `CHK("upper dir", 2'b01, {ramSelect, sfrSelect})
      dataMode = MSXAC_AM_BIT;
      dataAddr = 8'h0B;
      #1 `CHK("bit addr", 11'h10B, {ramIndex, bitIndex})
      wr(STACK_ADDR, 8'hFF);
      rdchk(STACK_ADDR, 8'hFF);
   endtask
   task automatic t_freeze;
      clkEn = 1'b0;
      wr(STACK_ADDR, 8'h55);
      dataPointer = 16'hFC05;
      xmv(1'b0, 1'b1, 1'b0, 8'h00);
      `CHK("frozen stack", 8'hFF, stackPointer)
      `CHK("frozen hit", 1'b0, xramHit)
      `CHK("frozen bus", 1'b0, xBus.rdActive)
      clkEn = 1'b1;
   endtask
   task automatic results;
      if (errTotal == 0 && nCompared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #40000;
      errTotal++;
      results();
   end
   initial begin
      {reset, sfrWrite, sfrRead} = 3'b100;
      {extAccessPin, progCounter, dataPointer} = '0;
      {sfrAddr, sfrWdata, dataAddr, pointerRegZero, pointerRegOne} = '0;
      opcodeReg = 3'd0;
      clkEn     = 1'b1;
      dataMode  = MSXAC_AM_DIRECT;
      xReq      = '0;
      errTotal  = 0;
      nCompared = 0;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_fetch();
      t_disabled();
      t_enable();
      t_visible();
      t_page();
      t_decode();
      t_freeze();
      results();
   end
endmodule // tb
